// *** logic/flash_guard_host.sv ***
// host side write sequencer for a protected parallel nor flash
`timescale 1ns/1ps
`default_nettype none
module flash_guard_host
  import guard_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire guard_pkg::req_t  req,
  input  wire logic             req_valid,
  output logic                  req_ready,
  output logic                  done,
  output logic                  in_region,
  output var guard_pkg::bus_t   flash_bus,
  output logic                  boot_guard_accel_pin,
  output logic                  data_oe_n
);
  import guard_pkg::*;

  // ------------------------------------------------------------
  // write cycle sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_PULSE,
    S_HOLD,
    S_NEXT
  } state_t;

  state_t            state_q, state_d;
  req_t              cur_q, cur_d;
  logic [1:0]        step_q, step_d;
  logic [1:0]        last_q, last_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              region_q, region_d;
  logic              done_q, done_d;
  bus_t              bus_q, bus_d;

  // one bus word of the current sequence step
  function automatic bus_t step_word(input req_t r, input logic [1:0] s);
    bus_t b;
    b = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: r.addr, data: r.data};
    case (s)
      2'h0: begin
        b.addr = UNLOCK_ADDR1;
        b.data = UNLOCK_DATA1;
      end
      2'h1: begin
        b.addr = UNLOCK_ADDR2;
        b.data = UNLOCK_DATA2;
      end
      2'h2: begin
        b.addr = UNLOCK_ADDR1;
        case (r.op)
          OP_PROGRAM:      b.data = CMD_PROGRAM;
          OP_REGION_ENTER: b.data = CMD_REGION_ENTER;
          default:         b.data = CMD_REGION_EXIT1;
        endcase
      end
      default: begin
        if (r.op == OP_REGION_EXIT) begin
          b.data = CMD_REGION_EXIT2;
        end
      end
    endcase
    return b;
  endfunction

  always_comb begin
    state_d  = state_q;
    cur_d    = cur_q;
    step_d   = step_q;
    last_d   = last_q;
    cnt_d    = cnt_q;
    region_d = region_q;
    done_d   = 1'b0;
    bus_d    = bus_q;
    case (state_q)
      S_IDLE: begin
        if (req_valid) begin
          cur_d = req;
          // raw writes skip unlock; every program gets unlock first
          step_d = (req.op == OP_RAW_WRITE) ? 2'h3 : STEP_ZERO;
          last_d = (req.op == OP_REGION_ENTER) ? 2'h2 : 2'h3;
          state_d = S_SETUP;
          cnt_d = CNT_W'(SETUP_CYC);
          bus_d = step_word(req,
                  (req.op == OP_RAW_WRITE) ? 2'h3 : STEP_ZERO);
        end
      end
      S_SETUP: begin
        // oe high before ce and we drop, so no read collides
        bus_d.oe_n = 1'b1;
        if (cnt_q == '0) begin
          bus_d.ce_n = 1'b0;
          bus_d.we_n = 1'b0;
          cnt_d = CNT_W'(WRITE_PULSE_CYC);
          state_d = S_PULSE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      S_PULSE: begin
        // strobe held many cycles, far beyond glitch width
        if (cnt_q == '0) begin
          bus_d.we_n = 1'b1;
          state_d = S_HOLD;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      S_HOLD: begin
        bus_d.ce_n = 1'b1;
        state_d = S_NEXT;
      end
      S_NEXT: begin
        if (step_q == last_q) begin
          if (cur_q.op == OP_REGION_ENTER) begin
            region_d = 1'b1;
          end else if (cur_q.op == OP_REGION_EXIT) begin
            region_d = 1'b0;
          end
          done_d = 1'b1;
          state_d = S_IDLE;
        end else begin
          step_d = step_q + 1'b1;
          bus_d = step_word(cur_q, step_q + 1'b1);
          cnt_d = CNT_W'(SETUP_CYC);
          state_d = S_SETUP;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q  <= S_IDLE;
      cur_q    <= '0;
      step_q   <= STEP_ZERO;
      last_q   <= STEP_ZERO;
      cnt_q    <= '0;
      region_q <= 1'b0;
      done_q   <= 1'b0;
      // strobes idle high out of reset, no spurious command
      bus_q    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                    addr: '0, data: '0};
    end else begin
      state_q  <= state_d;
      cur_q    <= cur_d;
      step_q   <= step_d;
      last_q   <= last_d;
      cnt_q    <= cnt_d;
      region_q <= region_d;
      done_q   <= done_d;
      bus_q    <= bus_d;
    end
  end

  assign req_ready = (state_q == S_IDLE);
  assign done      = done_q;
  assign in_region = region_q;
  assign flash_bus = bus_q;
  // data driven only while chip selected for a write
  assign data_oe_n = bus_q.ce_n;
  // guard pin held low: boot sectors stay locked, no accelerated path
  assign boot_guard_accel_pin = 1'b0;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence write_low_s;
    !flash_bus.we_n && !flash_bus.ce_n;
  endsequence

  write_strobe_legal_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    write_low_s |-> flash_bus.oe_n)
    else $error("write strobe with output enable low");

  pulse_width_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(flash_bus.we_n) |-> !flash_bus.we_n [*3])
    else $error("write pulse too short");

  unlock_first_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    req_valid && req_ready && req.op == OP_PROGRAM
    |=> step_q == STEP_ZERO && flash_bus.addr == UNLOCK_ADDR1
    && flash_bus.data == UNLOCK_DATA1)
    else $error("program command without unlock");

  region_enter_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    done && cur_q.op == OP_REGION_ENTER |-> in_region)
    else $error("region flag not set after enter");

  region_exit_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    done && cur_q.op == OP_REGION_EXIT |-> !in_region)
    else $error("region flag not cleared after exit");

  guard_pin_low_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    !boot_guard_accel_pin)
    else $error("boot guard pin released");

  ce_we_release_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(flash_bus.we_n) |-> !flash_bus.ce_n ##1 flash_bus.ce_n)
    else $error("chip select not released after write strobe");

  idle_quiet_a : assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == S_IDLE |-> flash_bus.we_n && flash_bus.ce_n)
    else $error("strobes active while idle");
endmodule : flash_guard_host
`default_nettype wire

// *** logic/guard_pkg.sv ***
// package: constants and carriers for the flash protection host controller
package guard_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 25;
  // least times, rounded up to whole cycles
  localparam int WRITE_PULSE_NS = 70;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // unlock and command words (word mode)
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_REGION_ENTER = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_REGION_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_REGION_EXIT2 = 16'h0000;
  localparam logic [1:0] STEP_ZERO = 2'h0;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_REGION_ENTER,
    OP_REGION_EXIT,
    OP_RAW_WRITE
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  // flash strobes, all active low
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_t;
endpackage : guard_pkg

// *** tb/flash_model.sv ***
// behavioural flash device: unlock decoder, boot guard, secured region map
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter logic [4:0] PROT_BLOCK = 5'h01
) (
  input  wire logic            nrst,
  input  wire guard_pkg::bus_t bus,
  input  wire logic            guard_pin,
  input  wire logic            high_voltage_level,
  output logic                 region,
  output logic [15:0]          prog_cnt
);
  import guard_pkg::*;
  logic [1:0] step;
  logic       exit_q;
  logic       boot_hit;
  logic       prot_hit;
  // customer lockable part: indicator bit fixed at zero, never changes
  localparam logic FACTORY_LOCKED = 1'b0;
  // stored protection: boot pair left open, one sector block protected
  assign prot_hit = (bus.addr[20:16] == PROT_BLOCK);
  // ------------------------------------------------------------
  // top boot part: the two highest 4K-word sectors are outermost
  // ------------------------------------------------------------
  assign boot_hit = (bus.addr[20:13] == 8'hff);
  always @(posedge bus.we_n or negedge nrst) begin
    if (!nrst) begin
      step     <= 2'h0;
      region   <= 1'b0;
      exit_q   <= 1'b0;
      prog_cnt <= 16'h0000;
    end else if (!bus.ce_n && bus.oe_n) begin
      case (step)
        2'h0: step <= (bus.addr == UNLOCK_ADDR1 &&
                       bus.data == UNLOCK_DATA1) ? 2'h1 : 2'h0;
        2'h1: step <= (bus.addr == UNLOCK_ADDR2 &&
                       bus.data == UNLOCK_DATA2) ? 2'h2 : 2'h0;
        2'h2: begin
          step   <= 2'h0;
          exit_q <= (bus.data == CMD_REGION_EXIT1);
          if (bus.addr == UNLOCK_ADDR1 && bus.data == CMD_REGION_ENTER)
            region <= 1'b1;
          if (bus.addr == UNLOCK_ADDR1 && (bus.data == CMD_PROGRAM ||
              bus.data == CMD_REGION_EXIT1))
            step <= 2'h3;
        end
        default: begin
          step <= 2'h0;
          if (exit_q && bus.data == CMD_REGION_EXIT2)
            region <= 1'b0;
          // mapped region overlays the boot pair; a fixed part refuses all
          else if (!exit_q && region && boot_hit) begin
            if (!FACTORY_LOCKED)
              prog_cnt <= prog_cnt + 16'h0001;
          end
          // guard pin low refuses the outermost pair, even at high voltage
          else if (!exit_q && !(boot_hit && !guard_pin)
                   && !(prot_hit && !high_voltage_level))
            prog_cnt <= prog_cnt + 16'h0001;
        end
      endcase
    end
  end
endmodule // flash_model
`default_nettype wire

// *** tb/tb_flash_guard_host.sv ***
// self-checking bench for the flash protection host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_guard_host;
  import guard_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        req_valid = 1'b0;
  req_t        req = '0;
  logic        req_ready, done, in_region, guard_pin, data_oe_n, region;
  bus_t        flash_bus;
  logic [15:0] prog_cnt;
  logic [15:0] exp_cnt = 16'h0000;
  logic [17:0] notes[$];
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed = 41;
  logic        hv = 1'b0;
  logic [20:0] ra;
  localparam logic [4:0] PROT_BLOCK = 5'h01;

  initial forever #12.5 clk_sys = ~clk_sys;

  flash_guard_host flash_guard_host_i (.clk_sys(clk_sys), .nrst(nrst),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .done(done),
    .in_region(in_region), .flash_bus(flash_bus),
    .boot_guard_accel_pin(guard_pin), .data_oe_n(data_oe_n));
  flash_model #(.PROT_BLOCK(PROT_BLOCK)) flash_model_i (.nrst(nrst),
    .bus(flash_bus), .guard_pin(guard_pin), .high_voltage_level(hv),
    .region(region), .prog_cnt(prog_cnt));

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checked %0d, wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one request, note the expected result, wait for completion
  task automatic run(input op_t op, input logic [20:0] a,
                     input logic [15:0] d, input logic reg_e,
                     input logic [15:0] inc);
    int n;
    exp_cnt = exp_cnt + inc;
    notes.push_back({reg_e, reg_e, exp_cnt});
    req       = '{op, a, d};
    req_valid = 1'b1;
    @(posedge clk_sys);
    #2 req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) miscompares++;
    @(posedge clk_sys);
    #2;
    $display("test op %0d done", op);
  endtask

  // ------------------------------------------------------------
  // monitor: each done pulse retires the oldest note
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (done === 1'b1) begin
      check({16'h0000, data_oe_n, req_ready}, 18'h00003);
      if (notes.size() > 0)
        check({in_region, region, prog_cnt}, notes.pop_front());
      else
        miscompares++;
    end
    // data driven and requests refused while the write strobe is low
    if (flash_bus.we_n === 1'b0)
      check({16'h0000, data_oe_n, req_ready}, 18'h00000);
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #2 nrst = 1'b1;
    run(OP_PROGRAM, 21'h001000, 16'($random(seed)), 1'b0, 16'h1);
    run(OP_PROGRAM, 21'h1ff000, 16'($random(seed)), 1'b0, 16'h0);
    run(OP_PROGRAM, 21'h1fe800, 16'($random(seed)), 1'b0, 16'h0);
    run(OP_PROGRAM, 21'h1fd000, 16'($random(seed)), 1'b0, 16'h1);
    run(OP_PROGRAM, 21'h010400, 16'($random(seed)), 1'b0, 16'h0);
    hv = 1'b1;
    run(OP_PROGRAM, 21'h010400, 16'($random(seed)), 1'b0, 16'h1);
    run(OP_PROGRAM, 21'h1ff800, 16'($random(seed)), 1'b0, 16'h0);
    hv = 1'b0;
    run(OP_PROGRAM, 21'h010400, 16'($random(seed)), 1'b0, 16'h0);
    run(OP_REGION_ENTER, 21'h0, 16'h0, 1'b1, 16'h0);
    run(OP_PROGRAM, 21'h1ff000, 16'($random(seed)), 1'b1, 16'h1);
    run(OP_RAW_WRITE, UNLOCK_ADDR1, CMD_PROGRAM, 1'b1, 16'h0);
    run(OP_REGION_EXIT, 21'h0, 16'h0, 1'b0, 16'h0);
    repeat (4) begin
      ra = {1'b0, 20'($random(seed))};
      run(OP_PROGRAM, ra, 16'($random(seed)), 1'b0,
          16'(ra[20:16] != PROT_BLOCK));
    end
    run(OP_REGION_ENTER, 21'h0, 16'h0, 1'b1, 16'h0);
    nrst = 1'b0;
    exp_cnt = 16'h0000;
    @(posedge clk_sys);
    #2 nrst = 1'b1;
    @(posedge clk_sys);
    #2 check({in_region, region, prog_cnt}, {2'b00, exp_cnt});
    $display("test reset done");
    final_report;
  end

  initial begin
    #(25 * 4000);
    miscompares++;
    final_report;
  end
endmodule // tb_flash_guard_host
`default_nettype wire
